// *** src/tec_params.svh ***
// constants of the 16-bit timer/event counter
`ifndef TEC_PARAMS_SVH
`define TEC_PARAMS_SVH
// ****************************************
// register offsets
// ****************************************
`define TEC_OFF_MODE 8'h00
`define TEC_OFF_PRESC 8'h04
`define TEC_OFF_CCR 8'h08
`define TEC_OFF_CR1 8'h0C
`define TEC_OFF_CR2 8'h10
`define TEC_OFF_COUNT 8'h14
`define TEC_OFF_LAST 8'h14
// ****************************************
// field positions
// ****************************************
`define TEC_MODE_OVF 0
`define TEC_MODE_LO 2
`define TEC_MODE_HI 3
`define TEC_PRESC_SEL_LO 0
`define TEC_PRESC_SEL_HI 1
`define TEC_EDGE1_LO 4
`define TEC_EDGE1_HI 5
`define TEC_EDGE2_LO 6
`define TEC_EDGE2_HI 7
`define TEC_CCR_CAP1 0
`define TEC_CCR_CAP2 2
// ****************************************
// reset values and counts
// ****************************************
`define TEC_RST_16 16'h0000
`define TEC_RST_8 8'h00
`define TEC_MAX 16'hFFFF
`define TEC_DIV0 8'h01
`define TEC_DIV1 8'h04
`define TEC_DIV2 8'h10
`define TEC_RESP_OKAY 2'h0
`define TEC_RESP_SLVERR 2'h2
`endif

// *** src/tec_pkg.sv ***
// types of the 16-bit timer/event counter
package tec_pkg;
    typedef enum logic [1:0] {
        TEC_STOP,
        TEC_CLR_EDGE,
        TEC_FREE,
        TEC_CLR_MATCH
    } tec_mode_t;

    typedef struct packed {
        logic en;
        logic [7:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
    } tec_wr_t;
endpackage

// *** src/tec_edge_det.sv ***
// valid-edge detector for one external pin
`timescale 1ns/1ps
module tec_edge_det (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // pin and edge select: 00 fall, 01 rise, 10 none, 11 both
    input wire logic pin,
    input wire logic [1:0] sel,
    // one-cycle event
    output logic evt
);
    import tec_pkg::*;
    logic prev_r, prev_nxt, evt_r, evt_nxt;

    always_comb begin
        prev_nxt = pin;
        unique case (sel)
            2'h0: evt_nxt = prev_r & ~pin;
            2'h1: evt_nxt = ~prev_r & pin;
            2'h2: evt_nxt = 1'b0;
            default: evt_nxt = prev_r ^ pin;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prev_r <= 1'b0;
            evt_r <= 1'b0;
        end else if (ce) begin
            prev_r <= prev_nxt;
            evt_r <= evt_nxt;
        end
    end

    assign evt = evt_r;
endmodule // tec_edge_det

// *** src/tec_axil_slave.sv ***
// axi4-lite slave front end for the timer registers
`timescale 1ns/1ps
`include "tec_params.svh"
module tec_axil_slave (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // write channels
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // read channels
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // register side
    output tec_pkg::tec_wr_t wr,
    output logic [7:0] rd_addr,
    input wire logic [31:0] rd_data
);
    import tec_pkg::*;
    logic aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
    logic [7:0] awaddr_r, awaddr_nxt;
    logic [31:0] wdata_r, wdata_nxt;
    logic [3:0] wstrb_r, wstrb_nxt;
    logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    tec_wr_t wr_r, wr_nxt;
    logic awready_r, awready_nxt, wready_r, wready_nxt, arready_r, arready_nxt;

    function automatic logic hit(input logic [7:0] a);
        hit = (a[1:0] == 2'h0) && (a <= `TEC_OFF_LAST);
    endfunction

    always_comb begin
        aw_have_nxt = aw_have_r;
        w_have_nxt = w_have_r;
        awaddr_nxt = awaddr_r;
        wdata_nxt = wdata_r;
        wstrb_nxt = wstrb_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        rvalid_nxt = rvalid_r;
        rresp_nxt = rresp_r;
        rdata_nxt = rdata_r;
        wr_nxt = wr_r;
        wr_nxt.en = 1'b0;
        if (s_axi_awvalid && !aw_have_r) begin
            aw_have_nxt = 1'b1;
            awaddr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_have_r) begin
            w_have_nxt = 1'b1;
            wdata_nxt = s_axi_wdata;
            wstrb_nxt = s_axi_wstrb;
        end
        if (bvalid_r && s_axi_bready) begin
            bvalid_nxt = 1'b0;
        end
        if (aw_have_r && w_have_r && !bvalid_r) begin
            aw_have_nxt = 1'b0;
            w_have_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = hit(awaddr_r) ? `TEC_RESP_OKAY : `TEC_RESP_SLVERR;
            wr_nxt.en = hit(awaddr_r);
            wr_nxt.addr = awaddr_r;
            wr_nxt.data = wdata_r;
            wr_nxt.strb = wstrb_r;
        end
        if (rvalid_r && s_axi_rready) begin
            rvalid_nxt = 1'b0;
        end
        if (s_axi_arvalid && !rvalid_r) begin
            rvalid_nxt = 1'b1;
            rdata_nxt = hit(s_axi_araddr) ? rd_data : 32'h00000000;
            rresp_nxt = hit(s_axi_araddr) ? `TEC_RESP_OKAY : `TEC_RESP_SLVERR;
        end
        awready_nxt = !aw_have_nxt;
        wready_nxt = !w_have_nxt;
        arready_nxt = !rvalid_nxt;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            awaddr_r <= `TEC_RST_8;
            wdata_r <= 32'h00000000;
            wstrb_r <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r <= `TEC_RESP_OKAY;
            rvalid_r <= 1'b0;
            rresp_r <= `TEC_RESP_OKAY;
            rdata_r <= 32'h00000000;
            wr_r <= '0;
            awready_r <= 1'b1;
            wready_r <= 1'b1;
            arready_r <= 1'b1;
        end else if (ce) begin
            awready_r <= awready_nxt;
            wready_r <= wready_nxt;
            arready_r <= arready_nxt;
            aw_have_r <= aw_have_nxt;
            w_have_r <= w_have_nxt;
            awaddr_r <= awaddr_nxt;
            wdata_r <= wdata_nxt;
            wstrb_r <= wstrb_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            rvalid_r <= rvalid_nxt;
            rresp_r <= rresp_nxt;
            rdata_r <= rdata_nxt;
            wr_r <= wr_nxt;
        end
    end

    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rresp = rresp_r;
    assign s_axi_rdata = rdata_r;
    assign wr = wr_r;
    assign rd_addr = s_axi_araddr;
endmodule // tec_axil_slave

// *** src/tec_timer.sv ***
// 16-bit timer/event counter with two capture/compare registers
//
// Our own choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`include "tec_params.svh"
module tec_timer #(
    parameter int CNT_W = 16
) (
    // clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // axi4-lite write
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // external pins
    input wire logic edge_input_first,
    input wire logic edge_input_second,
    // status and events
    output logic [CNT_W-1:0] count_value,
    output logic overflow_flag,
    output logic match_capture_irq,
    output logic second_match_irq
);
    import tec_pkg::*;
    tec_wr_t wr;
    logic [7:0] rd_addr;
    logic [31:0] rd_data;
    logic ev1, ev2;
    // ****************************************
    // state
    // ****************************************
    tec_mode_t mode_r, mode_nxt;
    logic [7:0] prm_r, prm_nxt, ccr_r, ccr_nxt, pre_r, pre_nxt, div;
    logic [CNT_W-1:0] cnt_r, cnt_nxt, cr1_r, cr1_nxt, cr2_r, cr2_nxt;
    logic ovf_r, ovf_nxt, hold_r, hold_nxt;
    logic clrp_r, clrp_nxt, cap1p_r, cap1p_nxt, cap2p_r, cap2p_nxt;
    logic irqp1_r, irqp1_nxt, irqp2_r, irqp2_nxt;
    logic irq1_r, irq1_nxt, irq2_r, irq2_nxt;
    logic run, ext, tick, clr_eff, cap1_eff, cap2_eff, wrap;

    tec_axil_slave u_bus (
        .aclk(aclk), .aresetn(aresetn), .ce(ce),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .wr(wr), .rd_addr(rd_addr), .rd_data(rd_data)
    );

    tec_edge_det u_edge1 (
        .aclk(aclk), .aresetn(aresetn), .ce(ce), .pin(edge_input_first),
        .sel(prm_r[`TEC_EDGE1_HI:`TEC_EDGE1_LO]), .evt(ev1)
    );

    tec_edge_det u_edge2 (
        .aclk(aclk), .aresetn(aresetn), .ce(ce), .pin(edge_input_second),
        .sel(prm_r[`TEC_EDGE2_HI:`TEC_EDGE2_LO]), .evt(ev2)
    );

    function automatic logic [15:0] merge16(input logic [15:0] old,
            input logic [31:0] d, input logic [3:0] s);
        merge16 = old;
        if (s[0]) merge16[7:0] = d[7:0];
        if (s[1]) merge16[15:8] = d[15:8];
    endfunction

    // ****************************************
    // read mux
    // ****************************************
    always_comb begin
        rd_data = 32'h00000000;
        unique case (rd_addr)
            `TEC_OFF_MODE: rd_data = {28'h0000000, mode_r, 1'b0, ovf_r};
            `TEC_OFF_PRESC: rd_data = {24'h000000, prm_r};
            `TEC_OFF_CCR: rd_data = {24'h000000, ccr_r};
            `TEC_OFF_CR1: rd_data = {16'h0000, cr1_r};
            `TEC_OFF_CR2: rd_data = {16'h0000, cr2_r};
            `TEC_OFF_COUNT: rd_data = {16'h0000, cnt_r};
            default: rd_data = 32'h00000000;
        endcase
    end

    // ****************************************
    // count clock and counter
    // ****************************************
    always_comb begin
        run = (mode_r != TEC_STOP);
        ext = (prm_r[`TEC_PRESC_SEL_HI:`TEC_PRESC_SEL_LO] == 2'h3);
        unique case (prm_r[`TEC_PRESC_SEL_HI:`TEC_PRESC_SEL_LO])
            2'h0: div = `TEC_DIV0;
            2'h1: div = `TEC_DIV1;
            default: div = `TEC_DIV2;
        endcase
        tick = run && (ext ? ev1 : (pre_r == div - 8'h01));
        clr_eff = clrp_r | (ev1 && mode_r == TEC_CLR_EDGE);
        cap1_eff = cap1p_r | (ev2 && ccr_r[`TEC_CCR_CAP1]);
        cap2_eff = cap2p_r | (ev1 && ccr_r[`TEC_CCR_CAP2]);
        wrap = (cnt_r == `TEC_MAX);
        mode_nxt = mode_r;
        prm_nxt = prm_r;
        ccr_nxt = ccr_r;
        cr1_nxt = cr1_r;
        cr2_nxt = cr2_r;
        ovf_nxt = ovf_r;
        hold_nxt = hold_r;
        pre_nxt = (tick || ext) ? `TEC_RST_8 : pre_r + 8'h01;
        cnt_nxt = cnt_r;
        clrp_nxt = clr_eff;
        cap1p_nxt = cap1_eff;
        cap2p_nxt = cap2_eff;
        irqp1_nxt = irqp1_r;
        irqp2_nxt = irqp2_r;
        irq1_nxt = 1'b0;
        irq2_nxt = 1'b0;
        if (wr.en) begin
            unique case (wr.addr)
                `TEC_OFF_MODE: if (wr.strb[0]) begin
                    mode_nxt = tec_mode_t'(wr.data[`TEC_MODE_HI:`TEC_MODE_LO]);
                    ovf_nxt = wr.data[`TEC_MODE_OVF];
                end
                `TEC_OFF_PRESC: if (wr.strb[0]) prm_nxt = wr.data[7:0];
                `TEC_OFF_CCR: if (wr.strb[0]) ccr_nxt = wr.data[7:0];
                `TEC_OFF_CR1: cr1_nxt = merge16(cr1_r, wr.data, wr.strb);
                `TEC_OFF_CR2: cr2_nxt = merge16(cr2_r, wr.data, wr.strb);
                default: ;
            endcase
        end
        if (hold_r) begin
            ovf_nxt = 1'b1;
        end
        if (!run) begin
            pre_nxt = `TEC_RST_8;
            cnt_nxt = `TEC_RST_16;
            hold_nxt = 1'b0;
            clrp_nxt = 1'b0;
            cap1p_nxt = 1'b0;
            cap2p_nxt = 1'b0;
            irqp1_nxt = 1'b0;
            irqp2_nxt = 1'b0;
        end else if (tick) begin
            hold_nxt = 1'b0;
            clrp_nxt = 1'b0;
            cap1p_nxt = 1'b0;
            cap2p_nxt = 1'b0;
            if ((mode_r == TEC_CLR_MATCH && cnt_r == cr1_r) ||
                    (mode_r == TEC_CLR_EDGE && clr_eff)) begin
                cnt_nxt = `TEC_RST_16;
            end else begin
                cnt_nxt = cnt_r + 16'h0001;
            end
            if (wrap) begin
                ovf_nxt = 1'b1;
                hold_nxt = 1'b1;
            end
            irq1_nxt = irqp1_r || (!ccr_r[`TEC_CCR_CAP1] && cnt_r == cr1_r);
            irq2_nxt = irqp2_r || (!ccr_r[`TEC_CCR_CAP2] && cnt_r == cr2_r);
            irqp1_nxt = cap1_eff;
            irqp2_nxt = cap2_eff;
            if (cap1_eff) begin
                cr1_nxt = cnt_r;
            end
            if (cap2_eff) begin
                cr2_nxt = cnt_r;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_r <= TEC_STOP;
            prm_r <= `TEC_RST_8;
            ccr_r <= `TEC_RST_8;
            pre_r <= `TEC_RST_8;
            cnt_r <= `TEC_RST_16;
            cr1_r <= `TEC_RST_16;
            cr2_r <= `TEC_RST_16;
            ovf_r <= 1'b0;
            hold_r <= 1'b0;
            clrp_r <= 1'b0;
            cap1p_r <= 1'b0;
            cap2p_r <= 1'b0;
            irqp1_r <= 1'b0;
            irqp2_r <= 1'b0;
            irq1_r <= 1'b0;
            irq2_r <= 1'b0;
        end else if (ce) begin
            mode_r <= mode_nxt;
            prm_r <= prm_nxt;
            ccr_r <= ccr_nxt;
            pre_r <= pre_nxt;
            cnt_r <= cnt_nxt;
            cr1_r <= cr1_nxt;
            cr2_r <= cr2_nxt;
            ovf_r <= ovf_nxt;
            hold_r <= hold_nxt;
            clrp_r <= clrp_nxt;
            cap1p_r <= cap1p_nxt;
            cap2p_r <= cap2p_nxt;
            irqp1_r <= irqp1_nxt;
            irqp2_r <= irqp2_nxt;
            irq1_r <= irq1_nxt;
            irq2_r <= irq2_nxt;
        end
    end

    assign count_value = cnt_r;
    assign overflow_flag = ovf_r;
    assign match_capture_irq = irq1_r;
    assign second_match_irq = irq2_r;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn || !ce);

    property p_stop_quiet;
        (mode_r == TEC_STOP) |=> (cnt_r == 16'h0000) && !irq1_r && !irq2_r;
    endproperty
    a_stop_quiet: assert property (p_stop_quiet) else $error("stopped counter active");

    property p_free_step;
        (mode_r == TEC_FREE && tick && !wrap) |=> cnt_r == $past(cnt_r) + 16'h0001;
    endproperty
    a_free_step: assert property (p_free_step) else $error("free count did not step");

    property p_free_wrap;
        (mode_r == TEC_FREE && tick && wrap) |=> cnt_r == 16'h0000;
    endproperty
    a_free_wrap: assert property (p_free_wrap) else $error("count did not wrap");

    property p_start;
        (mode_r == TEC_STOP && mode_nxt != TEC_STOP) |=> run && cnt_r == 16'h0000 && pre_r == 8'h00;
    endproperty
    a_start: assert property (p_start) else $error("counter did not start");

    property p_ovf_set;
        (tick && wrap && cr1_r == 16'hFFFF) |=> ovf_r ##1 ovf_r;
    endproperty
    a_ovf_set: assert property (p_ovf_set) else $error("overflow flag not set");

    property p_ovf_hold;
        (hold_r && run) |=> ovf_r;
    endproperty
    a_ovf_hold: assert property (p_ovf_hold) else $error("overflow clear not undone");

    property p_cap_irq;
        (tick && cap1_eff) |=> (cr1_r == $past(cnt_r)) && irqp1_r && !irq1_r;
    endproperty
    a_cap_irq: assert property (p_cap_irq) else $error("capture timing wrong");

    property p_second_match;
        (run && tick && !ccr_r[`TEC_CCR_CAP2] && cnt_r == cr2_r) |=> second_match_irq;
    endproperty
    a_second_match: assert property (p_second_match) else $error("second match lost");
endmodule // tec_timer

// *** testbench/tec_pin_model.sv ***
// model of the two external edge input pins
`timescale 1ns/1ps
module tec_pin_model #(
    parameter int PULSE_W = 40
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // requests from the bench
    input wire logic run_first,
    input wire logic step_first,
    input wire logic pulse_second,
    // pins
    output logic pin_first = 1'b0,
    output logic pin_second = 1'b0
);
    // ****************************************
    // pin drive: toggles on the first pin, wide pulses on the second
    // ****************************************
    int hold = 0;
    always @(posedge aclk) begin
        if (!aresetn) begin
            pin_first <= 1'b0;
            pin_second <= 1'b0;
            hold = 0;
        end else begin
            if (run_first || step_first) begin
                pin_first <= !pin_first;
            end
            if (pulse_second) begin
                hold = PULSE_W;
            end
            pin_second <= (hold > 0);
            if (hold > 0) begin
                hold = hold - 1;
            end
        end
    end
endmodule // tec_pin_model

// *** testbench/timer_event_counter_16bit_tb.sv ***
// self-checking bench of the 16-bit timer/event counter
`timescale 1ns/1ps
`include "tec_params.svh"
module timer_event_counter_16bit_tb;
    import tec_pkg::*;
    // ****************************************
    // signals
    // ****************************************
    logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h00000000, rdata;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid, ovf, irq1, irq2, pin1, pin2;
    logic [1:0] bresp, rresp, resp;
    logic [15:0] cnt, c0;
    logic run1 = 1'b0, step1 = 1'b0, pulse2 = 1'b0;
    logic [31:0] d, div, v;
    int n_fail = 0, total_checks = 0, cyc = 0, n_irq1 = 0, n_irq2 = 0, n, off;

    always #5 aclk = !aclk;

    tec_timer uut (.aclk(aclk), .aresetn(aresetn), .ce(ce),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .edge_input_first(pin1),
        .edge_input_second(pin2), .count_value(cnt), .overflow_flag(ovf),
        .match_capture_irq(irq1), .second_match_irq(irq2));

    tec_pin_model pins (.aclk(aclk), .aresetn(aresetn), .run_first(run1),
        .step_first(step1), .pulse_second(pulse2), .pin_first(pin1), .pin_second(pin2));

    // ****************************************
    // report, timeout, irq counting
    // ****************************************
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    always @(posedge aclk) begin
        cyc++;
        if (irq1 === 1'b1) n_irq1++;
        if (irq2 === 1'b1) n_irq2++;
        if (cyc == 90000) begin
            n_fail++;
            $display("BAD %0t timeout", $time);
            report_and_stop();
        end
    end

    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t value %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_resp(input logic [1:0] got, input logic [1:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t response %h expected %h", $time, got, exp);
        end
    endtask

    // ****************************************
    // bus tasks
    // ****************************************
    task automatic axi_write(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= v;
        wstrb <= 4'hF;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (awvalid && awready === 1'b1) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready === 1'b1) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        v = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        axi_write(a, v, resp);
        check_resp(resp, `TEC_RESP_OKAY);
    endtask

    task automatic step_pin;
        step1 <= 1'b1;
        @(posedge aclk);
        step1 <= 1'b0;
        repeat (4) @(posedge aclk);
    endtask

    function automatic logic [31:0] div_of(input int sel);
        return (sel == 0) ? 32'h1 : (sel == 1) ? 32'h4 : 32'h10;
    endfunction

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        void'($urandom(32'h45FB0177));
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        // register access, unmapped and misaligned places
        axi_read(`TEC_OFF_COUNT, d, resp);
        check_val(d, 32'h0);
        d = $urandom;
        wr(`TEC_OFF_CR2, d);
        axi_read(`TEC_OFF_CR2, v, resp);
        check_val(v, {16'h0, d[15:0]});
        axi_read(8'h18, d, resp);
        check_resp(resp, `TEC_RESP_SLVERR);
        axi_write(8'h02, 32'h1, resp);
        check_resp(resp, `TEC_RESP_SLVERR);
        // stopped counter ignores both pins
        wr(`TEC_OFF_PRESC, 32'h33);
        wr(`TEC_OFF_CCR, 32'h01);
        n_irq1 = 0;
        n_irq2 = 0;
        run1 <= 1'b1;
        pulse2 <= 1'b1;
        @(posedge aclk);
        pulse2 <= 1'b0;
        repeat (20) @(posedge aclk);
        run1 <= 1'b0;
        repeat (60) @(posedge aclk);
        check_val(cnt, 32'h0);
        check_val(n_irq1 + n_irq2, 0);
        // internal prescaler codes 0 to 2, rotated from a random start
        off = $urandom % 3;
        for (int i = 0; i < 3; i++) begin
            wr(`TEC_OFF_MODE, 32'h00);
            wr(`TEC_OFF_PRESC, (i + off) % 3);
            wr(`TEC_OFF_CCR, 32'h00);
            div = div_of((i + off) % 3);
            wr(`TEC_OFF_MODE, 32'h08);
            for (int k = 0; k < 2; k++) begin
                c0 = cnt;
                n = 0;
                while (cnt === c0 && n < 100) begin
                    @(posedge aclk);
                    n++;
                end
            end
            check_val(n, div);
            check_val(cnt, c0 + 16'h1);
            wr(`TEC_OFF_MODE, 32'h00);
            repeat (2) @(posedge aclk);
            check_val(cnt, 32'h0);
        end
        // clear on first compare match, /1 clock
        wr(`TEC_OFF_PRESC, 32'h00);
        wr(`TEC_OFF_CR1, 32'h5);
        wr(`TEC_OFF_MODE, 32'h0C);
        n_irq1 = 0;
        repeat (60) @(posedge aclk);
        check_val(n_irq1, 9);
        check_val(cnt, 32'h5);
        // stop before freezing the clock, then clear and capture on a first-pin edge
        wr(`TEC_OFF_MODE, 32'h00);
        ce <= 1'b0;
        repeat (20) @(posedge aclk);
        ce <= 1'b1;
        wr(`TEC_OFF_PRESC, 32'h30);
        wr(`TEC_OFF_CCR, 32'h04);
        wr(`TEC_OFF_MODE, 32'h04);
        repeat (30) @(posedge aclk);
        n_irq2 = 0;
        step_pin();
        check_val(cnt, 32'h1);
        axi_read(`TEC_OFF_CR2, v, resp);
        check_val(v, 32'h20);
        check_val(n_irq2, 1);
        wr(`TEC_OFF_MODE, 32'h00);
        // capture on second pin, irq one count clock later
        wr(`TEC_OFF_PRESC, 32'h42);
        wr(`TEC_OFF_CCR, 32'h01);
        wr(`TEC_OFF_MODE, 32'h08);
        repeat (50) @(posedge aclk);
        n_irq1 = 0;
        pulse2 <= 1'b1;
        @(posedge aclk);
        pulse2 <= 1'b0;
        n = 0;
        while (irq1 !== 1'b1 && n < 300) begin
            @(posedge aclk);
            n++;
        end
        c0 = cnt;
        repeat (100) @(posedge aclk);
        axi_read(`TEC_OFF_CR1, d, resp);
        check_val(c0 - d[15:0], 32'h2);
        check_val(n_irq1, 1);
        // long run to the wrap, then single pin edges
        wr(`TEC_OFF_MODE, 32'h00);
        wr(`TEC_OFF_PRESC, 32'h33);
        wr(`TEC_OFF_CCR, 32'h00);
        wr(`TEC_OFF_CR1, 32'hFFFF);
        wr(`TEC_OFF_CR2, 32'h0000);
        wr(`TEC_OFF_MODE, 32'h08);
        run1 <= 1'b1;
        while (cnt < 16'hFFE0) @(posedge aclk);
        run1 <= 1'b0;
        repeat (6) @(posedge aclk);
        for (int k = 0; k < 64 && cnt !== 16'hFFFF; k++) step_pin();
        check_val(ovf, 32'h0);
        n_irq1 = 0;
        step_pin();
        check_val(cnt, 32'h0);
        check_val(ovf, 32'h1);
        check_val(n_irq1, 1);
        wr(`TEC_OFF_MODE, 32'h08);
        @(posedge aclk);
        check_val(ovf, 32'h1);
        n_irq2 = 0;
        step_pin();
        check_val(n_irq2, 1);
        wr(`TEC_OFF_MODE, 32'h08);
        @(posedge aclk);
        check_val(ovf, 32'h0);
        wr(`TEC_OFF_MODE, 32'h00);
        report_and_stop();
    end
endmodule // timer_event_counter_16bit_tb
